// ===== locr_regs.sv
`timescale 1ns/1ps
`include "locr_defs.svh"
module locr_regs
    import locr_pkg::*;
#(
    parameter int DW    = 12,
    parameter int STEPS = `LOCR_PHASE_STEPS
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire locr_wr_t         i_wr,
    input  wire logic [7:0]       i_rd_addr,
    input  wire logic [DW-1:0]    i_sample,
    input  wire logic [STEPS-1:0] i_phases,
    output logic [7:0]            o_rd_data,
    output locr_cfg_t             o_cfg,
    output logic [DW-1:0]         o_data,
    output logic                  o_bit_clock_out,
    output logic [9:0]            o_phase_deg
);
    logic [7:0] gain_reg;
    logic [7:0] fmt_reg;
    logic [7:0] drv_reg;
    logic [7:0] phase_reg;
    logic [3:0] sat_code;

    function automatic logic [7:0] wmask(input logic [7:0] d,
                                         input logic [7:0] m);
        return d & m;
    endfunction : wmask

    // Write strobe aimed at one register address
    function automatic logic wr_hit(input locr_wr_t   w,
                                    input logic [7:0] a);
        return w.wr && (w.addr == a);
    endfunction : wr_hit

    // Codes above the top step all give the largest offset
    function automatic logic [3:0] sat_phase(input logic [3:0] c);
        return (c > `LOCR_PHASE_MAX) ? `LOCR_PHASE_MAX : c;
    endfunction : sat_phase

    function automatic logic is_twos(input logic [7:0] f);
        return f[1:0] == `LOCR_FMT_TWOS;
    endfunction : is_twos

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gain_reg <= `LOCR_RST_GAIN;
        end else if (wr_hit(i_wr, `LOCR_ADDR_GAIN)) begin
            gain_reg <= wmask(i_wr.data, `LOCR_MASK_GAIN);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fmt_reg <= `LOCR_RST_FMT;
        end else if (wr_hit(i_wr, `LOCR_ADDR_FMT)) begin
            fmt_reg <= wmask(i_wr.data, `LOCR_MASK_FMT);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            drv_reg <= `LOCR_RST_DRV;
        end else if (wr_hit(i_wr, `LOCR_ADDR_DRV)) begin
            drv_reg <= wmask(i_wr.data, `LOCR_MASK_DRV);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            phase_reg <= `LOCR_RST_PHASE;
        end else if (wr_hit(i_wr, `LOCR_ADDR_PHASE)) begin
            phase_reg <= wmask(i_wr.data, `LOCR_MASK_PHASE);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rd_data <= 8'h00;
        end else begin
            unique case (i_rd_addr)
                `LOCR_ADDR_GAIN:  o_rd_data <= gain_reg;
                `LOCR_ADDR_FMT:   o_rd_data <= fmt_reg;
                `LOCR_ADDR_DRV:   o_rd_data <= drv_reg;
                `LOCR_ADDR_PHASE: o_rd_data <= phase_reg;
                default:          o_rd_data <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg <= '{gain_code: 2'h1, twos_comp: 1'b0, invert: 1'b0,
                       low_power: 1'b0, term: LOCR_TERM_NONE,
                       drive_2x: 1'b0, phase_sel: 4'h3};
        end else begin
            o_cfg.gain_code <= gain_reg[1:0];
            o_cfg.twos_comp <= is_twos(fmt_reg);
            o_cfg.invert    <= fmt_reg[`LOCR_FMT_INV_BIT];
            o_cfg.low_power <= fmt_reg[`LOCR_FMT_LOWPWR_BIT];
            unique case (drv_reg[`LOCR_DRV_TERM_LSB +: 2])
                2'h0:    o_cfg.term <= LOCR_TERM_NONE;
                2'h1:    o_cfg.term <= LOCR_TERM_200;
                default: o_cfg.term <= LOCR_TERM_100;
            endcase
            o_cfg.drive_2x  <= drv_reg[`LOCR_DRV_2X_BIT];
            o_cfg.phase_sel <= phase_reg[3:0];
        end
    end

    // Sample path: format and invert only, never touched by phase code
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_data <= '0;
        end else begin
            o_data <= {i_sample[DW-1] ^ is_twos(fmt_reg),
                       i_sample[DW-2:0]} ^
                      {DW{fmt_reg[`LOCR_FMT_INV_BIT]}};
        end
    end

    always_comb begin
        sat_code = sat_phase(phase_reg[3:0]);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_phase_deg <= `LOCR_RST_DEG;
        end else begin
            o_phase_deg <= 10'(sat_code * `LOCR_PHASE_DEG);
        end
    end

    locr_phase_sel #(
        .STEPS     (STEPS)
    ) u_phase (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_code    (phase_reg[3:0]),
        .i_phases  (i_phases),
        .o_clk_sel (o_bit_clock_out)
    );

    a_gain_reset: assert property (
        @(posedge i_clk) $rose(i_rst_n) |-> gain_reg == `LOCR_RST_GAIN)
        else $error("gain reset wrong");
    a_phase_reset: assert property (
        @(posedge i_clk) $rose(i_rst_n) |-> phase_reg == `LOCR_RST_PHASE)
        else $error("phase reset wrong");
    a_fmt_drv_reset: assert property (
        @(posedge i_clk) $rose(i_rst_n) |->
        fmt_reg == `LOCR_RST_FMT && drv_reg == `LOCR_RST_DRV)
        else $error("format or driver reset wrong");
    a_gain_write: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        wr_hit(i_wr, `LOCR_ADDR_GAIN) |=>
        gain_reg == ($past(i_wr.data) & `LOCR_MASK_GAIN))
        else $error("gain write wrong");
    a_fmt_write: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        wr_hit(i_wr, `LOCR_ADDR_FMT) |=>
        fmt_reg == ($past(i_wr.data) & `LOCR_MASK_FMT))
        else $error("format write wrong");
    a_drv_write: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        wr_hit(i_wr, `LOCR_ADDR_DRV) |=>
        drv_reg == ($past(i_wr.data) & `LOCR_MASK_DRV))
        else $error("driver write wrong");
    a_phase_write: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        wr_hit(i_wr, `LOCR_ADDR_PHASE) |=>
        phase_reg == ($past(i_wr.data) & `LOCR_MASK_PHASE))
        else $error("phase write wrong");
    a_wr_other_ignored: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_wr.wr && !(i_wr.addr inside {`LOCR_ADDR_GAIN, `LOCR_ADDR_FMT,
                                       `LOCR_ADDR_DRV, `LOCR_ADDR_PHASE})
        |=> $stable(gain_reg) && $stable(fmt_reg) &&
            $stable(drv_reg) && $stable(phase_reg))
        else $error("stray write landed");
    a_rd_unmapped: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !(i_rd_addr inside {`LOCR_ADDR_GAIN, `LOCR_ADDR_FMT,
                            `LOCR_ADDR_DRV, `LOCR_ADDR_PHASE})
        |=> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    a_rd_gain: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_rd_addr == `LOCR_ADDR_GAIN |=> o_rd_data == $past(gain_reg))
        else $error("gain readback wrong");
    a_rd_phase: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_rd_addr == `LOCR_ADDR_PHASE |=> o_rd_data == $past(phase_reg))
        else $error("phase readback wrong");
    a_gain_cfg: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_cfg.gain_code == $past(gain_reg[1:0]))
        else $error("gain not forwarded");
    a_phase_deg_calc: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_phase_deg == 10'($past(sat_code) * `LOCR_PHASE_DEG))
        else $error("phase degrees wrong");
    a_phase_sat_top: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        phase_reg[3:0] >= 4'hB |=> o_phase_deg == `LOCR_PHASE_TOP_DEG)
        else $error("phase not saturated");
    a_phase_deg_zero: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        phase_reg[3:0] == 4'h0 |=> o_phase_deg == 10'h000)
        else $error("phase zero wrong");
    a_phase_deg_max: assert property (
        @(posedge i_clk) o_phase_deg <= `LOCR_PHASE_TOP_DEG)
        else $error("phase above top step");
    a_phase_sel_cfg: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_cfg.phase_sel == $past(phase_reg[3:0]))
        else $error("phase select not forwarded");
    a_fmt_twos: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        fmt_reg[1:0] == `LOCR_FMT_TWOS |=> o_cfg.twos_comp)
        else $error("twos select lost");
    a_fmt_offset: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        fmt_reg[1:0] != `LOCR_FMT_TWOS |=> !o_cfg.twos_comp)
        else $error("offset select lost");
    a_inv_cfg: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_cfg.invert == $past(fmt_reg[`LOCR_FMT_INV_BIT]))
        else $error("invert not forwarded");
    a_lowpwr_cfg: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_cfg.low_power == $past(fmt_reg[`LOCR_FMT_LOWPWR_BIT]))
        else $error("swing select wrong");
    a_term_none: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        drv_reg[5:4] == 2'h0 |=> o_cfg.term == LOCR_TERM_NONE)
        else $error("termination not off");
    a_term_200: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        drv_reg[5:4] == 2'h1 |=> o_cfg.term == LOCR_TERM_200)
        else $error("termination not 200");
    a_term_100: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        drv_reg[5] |=> o_cfg.term == LOCR_TERM_100)
        else $error("termination wrong");
    a_drive_2x: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        ##1 o_cfg.drive_2x == $past(drv_reg[0]))
        else $error("drive bit wrong");
    a_bclk_high: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_phases[sat_code] |=> o_bit_clock_out)
        else $error("clock tap high lost");
    a_bclk_low: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !i_phases[sat_code] |=> !o_bit_clock_out)
        else $error("clock tap low lost");
    a_data_offset: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        fmt_reg[1:0] != `LOCR_FMT_TWOS && !fmt_reg[`LOCR_FMT_INV_BIT]
        |=> o_data == $past(i_sample))
        else $error("offset data altered");
    a_data_invert: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        fmt_reg[1:0] != `LOCR_FMT_TWOS && fmt_reg[`LOCR_FMT_INV_BIT]
        |=> o_data == ~$past(i_sample))
        else $error("inverted data wrong");
    a_data_twos: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        fmt_reg[1:0] == `LOCR_FMT_TWOS && !fmt_reg[`LOCR_FMT_INV_BIT]
        |=> o_data == ($past(i_sample) ^ {1'b1, {(DW-1){1'b0}}}))
        else $error("twos data wrong");
    a_unused_zero: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (gain_reg & ~`LOCR_MASK_GAIN) == 8'h00 &&
        (drv_reg & ~`LOCR_MASK_DRV) == 8'h00)
        else $error("unused bit set");
    a_unused_fmt_phase: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        (fmt_reg & ~`LOCR_MASK_FMT) == 8'h00 &&
        (phase_reg & ~`LOCR_MASK_PHASE) == 8'h00)
        else $error("unused format or phase bit set");
    a_data_phase_free: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $changed(phase_reg) && $stable(fmt_reg) && $stable(i_sample)
        |=> $stable(o_data))
        else $error("data moved with phase");
    c_phase_write: cover property (@(posedge i_clk)
        i_wr.wr && i_wr.addr == `LOCR_ADDR_PHASE);
    c_phase_sat: cover property (@(posedge i_clk) phase_reg[3:0] == 4'hF);
    c_twos: cover property (@(posedge i_clk) o_cfg.twos_comp);
    c_term_200: cover property (@(posedge i_clk)
        o_cfg.term == LOCR_TERM_200);
    c_inv_twos: cover property (@(posedge i_clk)
        o_cfg.invert && o_cfg.twos_comp);
endmodule : locr_regs

// ===== locr_defs.svh
`ifndef LOCR_DEFS_SVH
`define LOCR_DEFS_SVH
`define LOCR_ADDR_GAIN      8'h11
`define LOCR_ADDR_FMT       8'h14
`define LOCR_ADDR_DRV       8'h15
`define LOCR_ADDR_PHASE     8'h16
`define LOCR_RST_GAIN       8'h01
`define LOCR_RST_FMT        8'h00
`define LOCR_RST_DRV        8'h00
`define LOCR_RST_PHASE      8'h03
`define LOCR_MASK_GAIN      8'h03
`define LOCR_MASK_FMT       8'h47
`define LOCR_MASK_DRV       8'h31
`define LOCR_MASK_PHASE     8'h0F
`define LOCR_FMT_LOWPWR_BIT 6
`define LOCR_FMT_INV_BIT    2
`define LOCR_DRV_TERM_LSB   4
`define LOCR_DRV_2X_BIT     0
`define LOCR_PHASE_MAX      4'hB
`define LOCR_PHASE_STEPS    12
`define LOCR_PHASE_DEG      60
`define LOCR_FMT_TWOS       2'h1
`define LOCR_RST_DEG        10'h0B4
`define LOCR_PHASE_TOP_DEG  10'h294
`endif

// ===== locr_pkg.sv
package locr_pkg;
    typedef enum logic [1:0] {
        LOCR_GAIN_5X = 2'h0,
        LOCR_GAIN_6X = 2'h1,
        LOCR_GAIN_8X = 2'h2,
        LOCR_GAIN_RSV = 2'h3
    } locr_gain_t;
    typedef enum logic [2:0] {
        LOCR_TERM_NONE = 3'h1,
        LOCR_TERM_200  = 3'h2,
        LOCR_TERM_100  = 3'h4
    } locr_term_t;
    typedef struct packed {
        logic [1:0] gain_code;
        logic       twos_comp;
        logic       invert;
        logic       low_power;
        locr_term_t term;
        logic       drive_2x;
        logic [3:0] phase_sel;
    } locr_cfg_t;
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] data;
    } locr_wr_t;
endpackage : locr_pkg

// ===== locr_phase_sel.sv
`timescale 1ns/1ps
`include "locr_defs.svh"
module locr_phase_sel
    import locr_pkg::*;
#(
    parameter int STEPS = `LOCR_PHASE_STEPS
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic [3:0]       i_code,
    input  wire logic [STEPS-1:0] i_phases,
    output logic                  o_clk_sel
);
    logic [3:0] idx;
    // Codes above the top step saturate
    always_comb begin
        idx = (i_code > `LOCR_PHASE_MAX) ? `LOCR_PHASE_MAX : i_code;
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_clk_sel <= 1'b0;
        end else begin
            o_clk_sel <= i_phases[idx];
        end
    end
endmodule : locr_phase_sel

// ===== tb_locr_regs.sv
`timescale 1ns/1ps
module tb_locr_regs;
    import locr_pkg::*;
    typedef struct packed {
        logic [2:0]  kind;
        logic [11:0] exp;
        int          due;
    } locr_note_t;
    logic        i_clk   = 1'b0;
    logic        i_rst_n = 1'b0;
    locr_wr_t    wr      = '0;
    logic [7:0]  rd_addr = 8'h00;
    logic [11:0] sample  = 12'h000;
    logic [11:0] phases  = 12'h000;
    logic [7:0]  rd_data;
    locr_cfg_t   cfg;
    logic [11:0] data;
    logic        bclk;
    logic [9:0]  deg;
    logic [15:0] rnd = 16'hB6E9;
    int          num_errors = 0;
    int          comparisons = 0;
    int          cyc = 0;
    locr_note_t  q[$];
    locr_note_t  n;
    string       names[8] = '{"rd_data", "phase_deg", "data", "bit_clock",
                              "phase_sel", "fmt_bits", "drv_bits", "gain"};
    logic [7:0]  ad[5] = '{8'h11, 8'h14, 8'h15, 8'h16, 8'h12};
    logic [7:0]  rv[5] = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00};
    logic [7:0]  mk[5] = '{8'h03, 8'h47, 8'h31, 8'h0F, 8'h00};
    locr_regs #(.DW(12), .STEPS(12)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_wr(wr), .i_rd_addr(rd_addr), .i_sample(sample), .i_phases(phases),
        .o_rd_data(rd_data), .o_cfg(cfg), .o_data(data),
        .o_bit_clock_out(bclk), .o_phase_deg(deg));
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;
    function automatic logic [11:0] seen(logic [2:0] k);
        case (k)
            3'h0: return {4'h0, rd_data};
            3'h1: return {2'h0, deg};
            3'h2: return data;
            3'h3: return {11'h000, bclk};
            3'h4: return {8'h00, cfg.phase_sel};
            3'h5: return {9'h000, cfg.twos_comp, cfg.invert, cfg.low_power};
            3'h6: return {8'h00, cfg.term, cfg.drive_2x};
            default: return {10'h000, cfg.gain_code};
        endcase
    endfunction : seen
    task automatic check(string what, logic [11:0] e, logic [11:0] s);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask : check
    // Monitor takes every note whose result has appeared by now
    always @(negedge i_clk) begin
        while (q.size() > 0 && q[0].due <= cyc) begin
            n = q.pop_front();
            check(names[n.kind], n.exp, seen(n.kind));
        end
    end
    task automatic note(logic [2:0] k, logic [11:0] e, int lat);
        q.push_back('{k, e, cyc + lat});
    endtask : note
    task automatic tick();
        @(negedge i_clk);
    endtask : tick
    function automatic logic [15:0] lfsr(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic step();
        rnd = lfsr(rnd);
    endtask : step
    task automatic wreg(logic [7:0] a, logic [7:0] d);
        wr = '{1'b1, a, d};
        tick();
        wr.wr = 1'b0;
        tick();
    endtask : wreg
    task automatic rreg(logic [7:0] a, logic [7:0] e);
        rd_addr = a;
        note(3'h0, {4'h0, e}, 1);
        tick();
    endtask : rreg
    task automatic done(string s);
        repeat (4) tick();
        $display("test %s done", s);
    endtask : done
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        #400000;
        num_errors++;
        summarize();
    end
    initial begin
        int s;
        repeat (16) tick();
        i_rst_n = 1'b1;
        note(3'h1, 12'd180, 0);
        note(3'h6, 12'h002, 0);
        for (int k = 0; k < 5; k++) rreg(ad[k], rv[k]);
        done("reset");
        for (int c = 0; c < 16; c++) begin
            s = (c > 10) ? 11 : c;
            note(3'h1, 12'(s * 60), 2);
            note(3'h4, 12'(c), 2);
            wreg(8'h16, 8'(c));
            step();
            phases = rnd[11:0];
            sample = rnd[15:4];
            note(3'h3, {11'h000, phases[s]}, 1);
            note(3'h2, sample, 1);
            repeat (2) tick();
        end
        done("phase");
        for (int g = 0; g < 4; g++) begin
            note(3'h7, 12'(g), 2);
            wreg(8'h11, 8'(g));
        end
        for (logic [3:0] i = 0; i < 8; i++) begin
            note(3'h5, {9'h000, i[2:0]}, 2);
            wreg(8'h14, {1'b0, i[0], 3'h0, i[1], 1'b0, i[2]});
            step();
            sample = rnd[11:0];
            note(3'h2, sample ^ {i[2], 11'h000} ^ {12{i[1]}}, 1);
            tick();
        end
        for (logic [2:0] t = 0; t < 4; t++) begin
            s = (t == 0) ? 1 : (t == 1) ? 2 : 4;
            note(3'h6, {8'h00, 3'(s), t[0]}, 2);
            wreg(8'h15, {2'h0, t[1:0], 3'h0, t[0]});
        end
        done("fields");
        for (int k = 0; k < 5; k++) begin
            wreg(ad[k], 8'hFF);
            rreg(ad[k], mk[k]);
            step();
            wreg(ad[k], rnd[7:0]);
            rreg(ad[k], rnd[7:0] & mk[k]);
        end
        done("masks");
        i_rst_n = 1'b0;
        repeat (2) tick();
        i_rst_n = 1'b1;
        rreg(8'h16, 8'h03);
        rreg(8'h11, 8'h01);
        done("rereset");
        summarize();
    end
endmodule : tb_locr_regs
